// ==== design/sls_pkg.sv ====
// Shared types and constants for the strap latch and speed indicator block.
// Assumes a single 25 MHz core clock and an analog strap sensor upstream that
// has already resolved the resistor option into a small code.
package sls_pkg;

    localparam int unsigned NUM_PORTS = 7;

    // Strap resistor option as reported by the strap sensing front end
    typedef enum logic [2:0]
    {
        SLS_RES_PD_200K = 3'h0,
        SLS_RES_PU_200K = 3'h1,
        SLS_RES_PD_10K  = 3'h2,
        SLS_RES_PU_10K  = 3'h3,
        SLS_RES_PD_10R  = 3'h4,
        SLS_RES_PU_10R  = 3'h5
    } sls_strap_code_t;

    localparam logic [2:0] STRAP_RESET_VAL = 3'h7;

    // Preset operating modes, one per resistor option, plus SLS_MODE_NONE for codes that name no resistor
    typedef enum logic [2:0]
    {
        SLS_MODE_INDICATOR_NO_SMBUS = 3'h0,
        SLS_MODE_INDICATOR_SMBUS    = 3'h1,
        SLS_MODE_RESERVED_A         = 3'h2,
        SLS_MODE_RESERVED_B         = 3'h3,
        SLS_MODE_CHARGE_INDICATOR   = 3'h4,
        SLS_MODE_RESERVED_C         = 3'h5,
        SLS_MODE_NONE               = 3'h7
    } sls_mode_t;

    // Per-port status from the hub port logic
    typedef struct packed
    {
        logic attached;
        logic super_speed;
    } sls_port_status_t;

    // Pin drive for one indicator pin
    typedef struct packed
    {
        logic level;
        logic oe;
    } sls_pin_drive_t;

    // Cycles after reset release before the strap is sampled, to let the pad settle
    localparam logic [3:0] STRAP_SETTLE_CYCLES = 4'h4;

endpackage : sls_pkg

// ==== design/sls_speed_encoder.sv ====
// Per-port encoder from attach state and speed to indicator pin drive.
// Assumes port status is synchronous to clk_in.
`timescale 1ns/1ps

module sls_speed_encoder
(
    input  wire logic                      enable_in,
    input  wire sls_pkg::sls_port_status_t status_in,
    output sls_pkg::sls_pin_drive_t        drive_out
);

    // Float when nothing attached, low for 2.0/1.1, high for 3.1 Gen 1
    // One assignment drives the whole struct so the output has a single driver
    assign drive_out = '{level: status_in.attached & status_in.super_speed,
                         oe:    enable_in & status_in.attached};

endmodule : sls_speed_encoder

// ==== design/sls_strap_latch.sv ====
// Strap latch and speed indicator top level.
// Assumes reset comes from the combined power-on and external chip reset, and that
// port status and strap code are synchronous to clk_in.
`timescale 1ns/1ps

// Notes on behaviour
// - The strap code is sampled after reset release and held as the configuration.
// - Capture happens after power-on reset and after every external reset release.
// - The captured resistor option selects one preset operating mode.
// - In the weak pull-down preset the SMBus stays disabled until the next reset.
// - In that preset seven pins become speed indicators for ports one to seven.
// - An indicator floats when unattached, drives 0 for 2.0/1.1 and 1 for 3.1 Gen 1.
module sls_strap_latch
(
    input  wire logic                                            clk_in,
    input  wire logic                                            rst_n_in,
    input  wire logic [2:0]                                      strap_code_in,
    input  wire sls_pkg::sls_port_status_t [sls_pkg::NUM_PORTS-1:0] port_status_in,
    output logic [2:0]                                           mode_out,
    output logic                                                 cfg_valid_out,
    output logic                                                 smbus_enable_out,
    output logic                                                 indicator_no_smbus_preset_out,
    output logic [sls_pkg::NUM_PORTS-1:0]                        port_speed_indicator_out,
    output logic [sls_pkg::NUM_PORTS-1:0]                        port_speed_indicator_oe_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture

    typedef enum logic [1:0] {SLS_ST_SETTLE, SLS_ST_HOLD} sls_state_t;

    sls_state_t  state_q;
    sls_state_t  state_d;
    logic [3:0]  settle_q;
    logic [3:0]  settle_d;
    logic [2:0]  mode_q;
    logic [2:0]  mode_d;
    logic        valid_q;
    logic        valid_d;
    logic        capture;

    function automatic logic [2:0] sls_decode(input logic [2:0] code);
        case (code)
            sls_pkg::SLS_RES_PD_200K: sls_decode = sls_pkg::SLS_MODE_INDICATOR_NO_SMBUS;
            sls_pkg::SLS_RES_PU_200K: sls_decode = sls_pkg::SLS_MODE_INDICATOR_SMBUS;
            sls_pkg::SLS_RES_PD_10K:  sls_decode = sls_pkg::SLS_MODE_RESERVED_A;
            sls_pkg::SLS_RES_PU_10K:  sls_decode = sls_pkg::SLS_MODE_RESERVED_B;
            sls_pkg::SLS_RES_PD_10R:  sls_decode = sls_pkg::SLS_MODE_CHARGE_INDICATOR;
            sls_pkg::SLS_RES_PU_10R:  sls_decode = sls_pkg::SLS_MODE_RESERVED_C;
            default:                  sls_decode = sls_pkg::SLS_MODE_NONE;
        endcase
    endfunction : sls_decode

    // Reset covers both POR and external reset, so every release re-latches
    assign capture = (state_q == SLS_ST_SETTLE) && (settle_q == sls_pkg::STRAP_SETTLE_CYCLES);

    always_comb
    begin
        state_d  = state_q;
        settle_d = settle_q;
        mode_d   = mode_q;
        valid_d  = valid_q;
        case (state_q)
            SLS_ST_SETTLE:
            begin
                settle_d = settle_q + 4'h1;
                if (capture)
                begin
                    mode_d   = sls_decode(strap_code_in);
                    valid_d  = 1'b1;
                    state_d  = SLS_ST_HOLD;
                    settle_d = settle_q;
                end
            end
            SLS_ST_HOLD:
            begin
                // Mode frozen for the session
                state_d = SLS_ST_HOLD;
            end
            default:
            begin
                state_d = SLS_ST_SETTLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_q  <= SLS_ST_SETTLE;
            settle_q <= 4'h0;
            mode_q   <= sls_pkg::STRAP_RESET_VAL;
            valid_q  <= 1'b0;
        end
        else
        begin
            state_q  <= state_d;
            settle_q <= settle_d;
            mode_q   <= mode_d;
            valid_q  <= valid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Indicator outputs

    logic                                    preset_hit;
    sls_pkg::sls_pin_drive_t [sls_pkg::NUM_PORTS-1:0] drive;
    logic [sls_pkg::NUM_PORTS-1:0]           ind_level;
    logic [sls_pkg::NUM_PORTS-1:0]           ind_oe;
    logic [sls_pkg::NUM_PORTS-1:0]           attached_bits;
    logic [sls_pkg::NUM_PORTS-1:0]           fast_bits;

    assign preset_hit = valid_q && (mode_q == sls_pkg::SLS_MODE_INDICATOR_NO_SMBUS);

    for (genvar p = 0; p < sls_pkg::NUM_PORTS; p++)
    begin : g_port
        sls_speed_encoder u_enc
        (
            .enable_in (preset_hit),
            .status_in (port_status_in[p]),
            .drive_out (drive[p])
        );
        assign ind_level[p] = drive[p].level;
        assign ind_oe[p]    = drive[p].oe;
        // Plain status copies give the checks a reference apart from the encoder
        assign attached_bits[p] = port_status_in[p].attached;
        assign fast_bits[p]     = port_status_in[p].attached & port_status_in[p].super_speed;
    end

    // Registered so pins never glitch; one cycle of lag on status changes
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            port_speed_indicator_out      <= '0;
            port_speed_indicator_oe_out   <= '0;
            smbus_enable_out              <= 1'b0;
            indicator_no_smbus_preset_out <= 1'b0;
            mode_out                      <= sls_pkg::STRAP_RESET_VAL;
            cfg_valid_out                 <= 1'b0;
        end
        else
        begin
            port_speed_indicator_out      <= ind_level;
            port_speed_indicator_oe_out   <= ind_oe;
            // SMBus held off until strap known, and for good in the preset
            smbus_enable_out              <= valid_q && !preset_hit;
            indicator_no_smbus_preset_out <= preset_hit;
            mode_out                      <= mode_q;
            cfg_valid_out                 <= valid_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    chk_strap_held: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        valid_q && $past(valid_q) |-> $stable(mode_q))
        else $error("strap mode changed after capture");

    chk_capture_time: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(rst_n_in) |-> ##5 valid_q)
        else $error("strap not captured after reset release");

    chk_decode_map: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        capture && strap_code_in == sls_pkg::SLS_RES_PD_200K |=> mode_q == sls_pkg::SLS_MODE_INDICATOR_NO_SMBUS)
        else $error("weak pull-down not decoded to indicator preset");

    chk_smbus_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        preset_hit |=> !smbus_enable_out)
        else $error("smbus enabled in indicator preset");

    chk_no_drive_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !preset_hit |=> port_speed_indicator_oe_out == '0)
        else $error("indicator driven outside preset");

    chk_float_unattached: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        preset_hit && !port_status_in[0].attached |=> !port_speed_indicator_oe_out[0])
        else $error("indicator driven with nothing attached");

    chk_speed_level: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        preset_hit && port_status_in[6].attached
        |=> port_speed_indicator_oe_out[6] && port_speed_indicator_out[6] == $past(port_status_in[6].super_speed))
        else $error("indicator level does not match speed");

    chk_follow_lag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        preset_hit && $stable(port_status_in) |=> port_speed_indicator_oe_out == $past(attached_bits))
        else $error("indicator did not follow status in one cycle");

    chk_valid_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $past(valid_q) |-> valid_q)
        else $error("captured configuration lost before reset");

    chk_mode_out_held: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        valid_q && $past(valid_q) |=> $stable(mode_out))
        else $error("mode output changed after capture");

    chk_no_early_capture: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(rst_n_in) |-> !valid_q [*5])
        else $error("strap captured before settle time");

    chk_decode_charge: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        capture && strap_code_in == sls_pkg::SLS_RES_PD_10R |=> mode_q == sls_pkg::SLS_MODE_CHARGE_INDICATOR)
        else $error("strong pull-down not decoded to charge indicator mode");

    chk_smbus_wait: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !valid_q |=> !smbus_enable_out)
        else $error("smbus enabled before strap capture");

    chk_preset_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        valid_q && mode_q == sls_pkg::SLS_MODE_INDICATOR_NO_SMBUS |=> indicator_no_smbus_preset_out)
        else $error("preset flag not raised in indicator preset");

    chk_slow_level: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        preset_hit && port_status_in[0].attached && !port_status_in[0].super_speed
        |=> port_speed_indicator_oe_out[0] && !port_speed_indicator_out[0])
        else $error("indicator not driven low for a slow connection");

    chk_level_follow: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        preset_hit |=> port_speed_indicator_out == $past(fast_bits))
        else $error("indicator level did not follow status in one cycle");

endmodule : sls_strap_latch

// ==== verif/sls_board_model.sv ====
// Board side of the block: fitted strap resistor and indicator pin wires.
// Assumes the bench picks the fitted resistor before each reset release.
`timescale 1ns/1ps

module sls_board_model
(
    input  wire logic       clk_in,
    input  wire logic [2:0] fitted_code_in,
    input  wire logic [6:0] level_in,
    input  wire logic [6:0] oe_in,
    output logic [2:0]      strap_code_out,
    output logic [6:0]      pin_out
);
    // Known start so a released pin is defined from the first cycle
    logic [6:0] last_q = 7'h00;

    // A fitted resistor never moves, so the strap is steady through capture
    assign strap_code_out = fitted_code_in;
    // A released pin toggles so that a stale level can never pass for a drive
    assign pin_out = (oe_in & level_in) | (~oe_in & ~last_q);

    always_ff @(posedge clk_in)
    begin
        last_q <= pin_out;
    end
endmodule : sls_board_model

// ==== verif/test_sls_strap_latch.sv ====
// Self-checking bench for the strap latch and speed indicator block.
// Assumes the board model above stands in for the strap and indicator pins.
`timescale 1ns/1ps

module test_sls_strap_latch;
    logic                                               clk_in;
    logic                                               rst_n_in;
    logic [2:0]                                         fitted;
    logic [2:0]                                         strap;
    sls_pkg::sls_port_status_t [sls_pkg::NUM_PORTS-1:0] status;
    logic [2:0]                                         mode;
    logic                                               valid;
    logic                                               smbus;
    logic                                               preset;
    logic [6:0]                                         lvl;
    logic [6:0]                                         oe;
    logic [6:0]                                         pin;
    int                                                 bad_count = 0;
    int                                                 checked = 0;

    sls_strap_latch dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .strap_code_in(strap),
        .port_status_in(status), .mode_out(mode), .cfg_valid_out(valid), .smbus_enable_out(smbus),
        .indicator_no_smbus_preset_out(preset), .port_speed_indicator_out(lvl),
        .port_speed_indicator_oe_out(oe));
    sls_board_model board_u (.clk_in(clk_in), .fitted_code_in(fitted), .level_in(lvl), .oe_in(oe),
        .strap_code_out(strap), .pin_out(pin));

    initial
    begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test

    // Reset with a given resistor fitted; capture lands on the fifth edge after release
    task automatic do_reset(input logic [2:0] code);
        fitted = code;
        rst_n_in = 1'b0;
        tick(2);
        check("mode in reset", 8'(mode), 8'h07);
        rst_n_in = 1'b1;
        tick(4);
        check("valid early", 8'(valid), 8'h00);
        tick(3);
    endtask : do_reset

    task automatic test_modes();
        logic [7:0] e_mode;
        for (int c = 0; c < 8; c++)
        begin
            // Codes six and seven name no resistor and fall back to the no-mode value
            e_mode = (c < 6) ? 8'(c) : 8'(sls_pkg::SLS_MODE_NONE);
            do_reset(3'(c));
            check("mode", 8'(mode), e_mode);
            check("valid", 8'(valid), 8'h01);
            check("smbus", 8'(smbus), 8'(c != 0));
            check("preset", 8'(preset), 8'(c == 0));
            fitted = 3'(5 - c);
            tick(3);
            check("mode held", 8'(mode), e_mode);
            check("smbus held", 8'(smbus), 8'(c != 0));
        end
        $display("test_modes done");
    endtask : test_modes

    task automatic test_indicators();
        logic [6:0] e_oe;
        logic [6:0] e_lvl;
        do_reset(3'h0);
        for (int s = 0; s < 3; s++)
        begin
            for (int p = 0; p < 7; p++)
            begin
                status[p] = '{attached: ((p + s) % 3) != 0, super_speed: ((p + s) % 3) == 2};
                e_oe[p] = ((p + s) % 3) != 0;
                e_lvl[p] = ((p + s) % 3) == 2;
            end
            tick(1);
            check("ind oe", 8'(oe), 8'(e_oe));
            check("ind level", 8'(lvl & e_oe), 8'(e_lvl));
            check("pin wire", 8'(pin & e_oe), 8'(e_lvl));
        end
        $display("test_indicators done");
    endtask : test_indicators

    task automatic test_other_mode();
        do_reset(3'h1);
        status = {7{2'h3}};
        tick(2);
        check("ind oe off", 8'(oe), 8'h00);
        $display("test_other_mode done");
    endtask : test_other_mode

    initial
    begin
        rst_n_in = 1'b0;
        fitted = 3'h0;
        status = '0;
        tick(12);
        test_modes();
        test_indicators();
        test_other_mode();
        finish_test();
    end

    initial
    begin
        #20000;
        bad_count++;
        finish_test();
    end
endmodule : test_sls_strap_latch
